// ---- common/paired_timer_pkg.sv ----
// Purpose: constants for the paired timer control block
// Assumes: 32-bit classic wishbone register bus, 50 MHz system clock
// Notes:   register offsets are byte addresses
package paired_timer_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
  localparam logic [7:0]  COUNT_OFFSET   = 8'h08;
  localparam logic [7:0]  PERIOD_OFFSET  = 8'h0C;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_WMASK     = 16'hA07A;
  localparam logic [31:0] PERIOD_RESET   = 32'hFFFFFFFF;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int RUN_BIT      = 15;
  localparam int IDLE_BIT     = 13;
  localparam int GATE_BIT     = 6;
  localparam int PRESC_HI_BIT = 5;
  localparam int PRESC_LO_BIT = 4;
  localparam int PAIR_BIT     = 3;
  localparam int CLKSRC_BIT   = 1;

  // ---------------------------------------------------------------
  // prescale codes and terminal counts
  // ---------------------------------------------------------------
  localparam logic [1:0] PRESC_DIV1   = 2'h0;
  localparam logic [1:0] PRESC_DIV8   = 2'h1;
  localparam logic [1:0] PRESC_DIV64  = 2'h2;
  localparam logic [1:0] PRESC_DIV256 = 2'h3;
  localparam logic [7:0] TC_DIV1      = 8'h00;
  localparam logic [7:0] TC_DIV8      = 8'h07;
  localparam logic [7:0] TC_DIV64     = 8'h3F;
  localparam logic [7:0] TC_DIV256    = 8'hFF;

endpackage : paired_timer_pkg

// ---- hdl/paired_timer_control.sv ----
// Purpose: control logic for two 16-bit timers joinable into one 32-bit timer
// Assumes: all inputs synchronous to sys_clk_i; wishbone classic slave
// Notes:   external clock pin counted on its rising edge
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module paired_timer_control
  import paired_timer_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        idle_mode_i,
  input  wire logic        ext_clk_i,
  input  wire logic        gate_i,
  input  wire logic        upper_tick_i,
  output logic             lower_match_o,
  output logic             upper_match_o,
  output logic             conv_trigger_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] ctrl_ff,   nxt_ctrl;
  logic [31:0] period_ff, nxt_period;
  logic [31:0] count_ff,  nxt_count;
  logic [7:0]  presc_ff,  nxt_presc;
  logic        ext_ff,    nxt_ext;
  logic [31:0] rdat_ff,   nxt_rdat;
  logic        ack_ff,    nxt_ack;
  logic        lmatch_ff, nxt_lmatch;
  logic        umatch_ff, nxt_umatch;
  logic        trig_ff,   nxt_trig;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] presc_limit(input logic [1:0] code);
    case (code)
      PRESC_DIV256: presc_limit = TC_DIV256;
      PRESC_DIV64:  presc_limit = TC_DIV64;
      PRESC_DIV8:   presc_limit = TC_DIV8;
      default:      presc_limit = TC_DIV1;
    endcase
  endfunction : presc_limit

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    byte_merge = r;
  endfunction : byte_merge

  logic        req;
  logic        wr_go;
  logic        pair;
  logic        run;
  logic        halted;
  logic        in_tick;
  logic        gate_ok;
  logic        presc_tick;
  logic        lo_hit;
  logic        hi_hit;
  logic        pair_hit;
  logic [31:0] merged_ctrl;

  always_comb
  begin
    req         = wb_cyc_i && wb_stb_i && !ack_ff;
    wr_go       = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff; // write lands on the ack edge
    merged_ctrl = byte_merge({16'h0000, ctrl_ff}, wb_dat_i, wb_sel_i);
    pair        = ctrl_ff[PAIR_BIT];
    run         = ctrl_ff[RUN_BIT];
    halted      = ctrl_ff[IDLE_BIT] && idle_mode_i;
    in_tick     = ctrl_ff[CLKSRC_BIT] ? (ext_clk_i && !ext_ff) : 1'b1;
    gate_ok     = ctrl_ff[CLKSRC_BIT] || !ctrl_ff[GATE_BIT] || gate_i;
    presc_tick  = run && !halted && in_tick && gate_ok
                  && (presc_ff == presc_limit(ctrl_ff[PRESC_HI_BIT:PRESC_LO_BIT]));
    lo_hit      = count_ff[15:0] == period_ff[15:0];
    hi_hit      = count_ff[31:16] == period_ff[31:16];
    pair_hit    = lo_hit && hi_hit;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_period = period_ff;
    nxt_count  = count_ff;
    nxt_presc  = presc_ff;
    nxt_ext    = ext_clk_i;
    nxt_rdat   = rdat_ff;
    nxt_ack    = req;
    nxt_lmatch = 1'b0;
    nxt_umatch = 1'b0;
    nxt_trig   = 1'b0;

    // prescaler, only advanced by qualified input edges
    if (run && !halted && in_tick && gate_ok)
    begin
      nxt_presc = presc_tick ? 8'h00 : presc_ff + 8'h01;
    end

    // counters and period matches
    if (presc_tick)
    begin
      if (pair)
      begin
        nxt_count = pair_hit ? 32'h00000000 : count_ff + 32'h00000001;
        nxt_umatch = pair_hit;
        nxt_trig   = pair_hit;
      end
      else
      begin
        nxt_count[15:0] = lo_hit ? 16'h0000 : count_ff[15:0] + 16'h0001;
        nxt_lmatch      = lo_hit;
      end
    end
    // upper timer runs on its own tick when not paired
    if (!pair && upper_tick_i)
    begin
      nxt_count[31:16] = hi_hit ? 16'h0000 : count_ff[31:16] + 16'h0001;
      nxt_umatch       = hi_hit;
      nxt_trig         = hi_hit;
    end

    if (wr_go)
    begin
      case (wb_adr_i)
        CTRL_OFFSET:
        begin
          nxt_ctrl = merged_ctrl[15:0] & CTRL_WMASK;
          if (run)
          begin
            nxt_presc = 8'h00;
          end
        end
        PERIOD_OFFSET: nxt_period = byte_merge(period_ff, wb_dat_i, wb_sel_i);
        COUNT_OFFSET:  nxt_count  = byte_merge(count_ff, wb_dat_i, wb_sel_i);
        default:       nxt_rdat   = rdat_ff;
      endcase
    end
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        CTRL_OFFSET:   nxt_rdat = {16'h0000, ctrl_ff};
        STATUS_OFFSET: nxt_rdat = {28'h0000000, halted, pair, run, presc_tick};
        COUNT_OFFSET:  nxt_rdat = count_ff;
        PERIOD_OFFSET: nxt_rdat = period_ff;
        default:       nxt_rdat = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_ff   <= CTRL_RESET;
      period_ff <= PERIOD_RESET;
      count_ff  <= 32'h00000000;
      presc_ff  <= 8'h00;
      ext_ff    <= 1'b0;
      rdat_ff   <= 32'h00000000;
      ack_ff    <= 1'b0;
      lmatch_ff <= 1'b0;
      umatch_ff <= 1'b0;
      trig_ff   <= 1'b0;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      period_ff <= nxt_period;
      count_ff  <= nxt_count;
      presc_ff  <= nxt_presc;
      ext_ff    <= nxt_ext;
      rdat_ff   <= nxt_rdat;
      ack_ff    <= nxt_ack;
      lmatch_ff <= nxt_lmatch;
      umatch_ff <= nxt_umatch;
      trig_ff   <= nxt_trig;
    end
  end

  always_comb
  begin
    wb_dat_o       = rdat_ff;
    wb_ack_o       = ack_ff;
    lower_match_o  = lmatch_ff;
    upper_match_o  = umatch_ff;
    conv_trigger_o = trig_ff;
  end

endmodule : paired_timer_control
`default_nettype wire

// ---- verification/paired_timer_control_chk.sv ----
// Purpose: port checker for paired_timer_control
// Assumes: control writes use all byte lanes
// Notes:   control word shadowed from acked bus writes
`timescale 1ns/1ps
`default_nettype none
module paired_timer_control_chk
  import paired_timer_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        idle_mode_i,
  input wire logic        gate_i,
  input wire logic        lower_match_o,
  input wire logic        upper_match_o,
  input wire logic        conv_trigger_o
);
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wb_ack_o && wb_we_i && wb_adr_i == CTRL_OFFSET)
      nxt_ctrl = wb_dat_i[15:0] & CTRL_WMASK;
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
      ctrl_ff <= CTRL_RESET;
    else
      ctrl_ff <= nxt_ctrl;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  AST_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  AST_TRIG_SRC:
    assert property (conv_trigger_o == upper_match_o) else $error("trigger source");
  AST_RUN_OFF:
    assert property (!ctrl_ff[15] [*3] |-> !lower_match_o) else $error("stopped lower");
  AST_PAIR_OFF:
    assert property (ctrl_ff[3] && !ctrl_ff[15] [*3] |-> !upper_match_o) else $error("pair off");
  AST_IDLE:
    assert property (ctrl_ff[13] && idle_mode_i [*3] |-> !lower_match_o) else $error("idle");
  AST_GATE:
    assert property (ctrl_ff[6] && !ctrl_ff[1] && !gate_i [*3] |-> !lower_match_o)
      else $error("gate low");
endmodule : paired_timer_control_chk
`default_nettype wire

// ---- verification/paired_timer_control_tb_top.sv ----
// Purpose: self-checking bench for paired_timer_control
// Assumes: answer within a few cycles
// Notes:   random periods and upper ticks from an lfsr
`timescale 1ns/1ps
`default_nettype none
module paired_timer_control_tb_top
  import paired_timer_pkg::*;
;
  logic        sys_clk_i = 1'h0, nrst_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0, idle_mode_i = 1'h0, ext_clk_i = 1'h0, gate_i = 1'h0;
  logic        upper_tick_i = 1'h0, ext_on = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, lower_match_o, upper_match_o, conv_trigger_o;
  logic [15:0] lfsr = 16'h000A;
  int          mismatches = 0, n_checks = 0, cycles = 0, c, p;
  paired_timer_control u_dut (.sys_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .idle_mode_i, .ext_clk_i,
    .gate_i, .upper_tick_i, .lower_match_o, .upper_match_o, .conv_trigger_o);
  always #10 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] step(input logic [15:0] v);
    step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : step
  function automatic int gap_exp(input int per, input int k);
    gap_exp = (per + 1) * (k == 0 ? 1 : k == 1 ? 8 : k == 2 ? 64 : 256);
  endfunction : gap_exp
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge sys_clk_i);
    while (wb_ack_o !== 1'h1)
    begin
      @(posedge sys_clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge sys_clk_i);
  endtask : wb
  task automatic pulse(input logic up);
    c = 0;
    do
    begin
      @(posedge sys_clk_i);
      c++;
    end
    while ((up ? upper_match_o : lower_match_o) !== 1'h1 && c < 9000);
  endtask : pulse
  task automatic run(input logic [15:0] ctl, input int per, input logic up, input int exp);
    wb(1'h1, PERIOD_OFFSET, 32'(per));
    // configure stopped, clear count, then start: first match one period away
    wb(1'h1, CTRL_OFFSET, {16'h0, ctl & 16'h7FFF});
    wb(1'h1, COUNT_OFFSET, 32'h0);
    wb(1'h1, CTRL_OFFSET, {16'h0, ctl});
    pulse(up);
    pulse(up);
    chk(32'(c), 32'(exp));
    wb(1'h1, CTRL_OFFSET, 32'h0);
  endtask : run
  task automatic quiet(input logic [15:0] ctl);
    wb(1'h1, CTRL_OFFSET, {16'h0, ctl});
    c = 0;
    repeat (200)
    begin
      @(posedge sys_clk_i);
      if (lower_match_o === 1'h1)
        c++;
    end
    chk(32'(c), 32'h0);
    wb(1'h1, CTRL_OFFSET, 32'h0);
  endtask : quiet
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    lfsr <= step(lfsr);
    upper_tick_i <= lfsr[0];
    ext_clk_i <= ext_on & ~ext_clk_i;
    if (cycles == 60000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    @(posedge sys_clk_i);
    wb(1'h0, CTRL_OFFSET, 32'h0);
    chk(q, 32'h0);
    wb(1'h0, PERIOD_OFFSET, 32'h0);
    chk(q, 32'hFFFFFFFF);
    wb(1'h0, STATUS_OFFSET, 32'h0);
    chk(q, 32'h0);
    wb(1'h1, CTRL_OFFSET, 32'h7FFF);
    wb(1'h0, CTRL_OFFSET, 32'h0);
    chk(q, 32'h207A);
    wb(1'h0, STATUS_OFFSET, 32'h0);
    chk(q, 32'h4);
    wb(1'h1, 8'h40, 32'hFFFFFFFF);
    wb(1'h0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'h1, CTRL_OFFSET, 32'h8);
    for (int k = 0; k < 4; k++)
    begin
      p = 4 * k + lfsr[1:0] + 1;
      run(16'h8000 | 16'(k << 4), p, 1'h0, gap_exp(p, k));
    end
    run(16'h8008, 20, 1'h1, 21);
    gate_i <= 1'h1;
    run(16'h8040, 21, 1'h0, 22);
    gate_i <= 1'h0;
    ext_on <= 1'h1;
    run(16'h8042, 22, 1'h0, 46);
    ext_on <= 1'h0;
    quiet(16'h8040);
    idle_mode_i <= 1'h1;
    run(16'h8000, 23, 1'h0, 24);
    quiet(16'hA000);
    stop_test();
  end
endmodule : paired_timer_control_tb_top
bind paired_timer_control paired_timer_control_chk u_chk (.sys_clk_i, .nrst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .idle_mode_i, .gate_i,
  .lower_match_o, .upper_match_o, .conv_trigger_o);
`default_nettype wire
